/* File: rtl/tsa_text_screen_arbiter.sv */
// Purpose: Picks the shown screen and language; runs arrow-key entry.
// Assumes: Enables, acknowledges and keys are asynchronous pins; configuration comes over APB.
// Notes: No state survives reset; everything restarts from the reset values.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Language follows the entry matching the select operand.
// - No match selects the default language.
// - Format follows the selected language.
// - Best enabled normal screen shows while enabled.
// - A dropped screen yields to the best enabled one.
// - A new alarm shows once older alarms are gone, until acknowledged.
// - After acknowledge: next alarm, else best screen.
// - Equal priorities rotate by their rolling times.
// - A better screen stops rotation.
// - Nothing is retained over reset.
// - With cursor keys enabled, the mode key enters input mode.
// - Input mode highlights fields and blinks the cursor.
// - Up adds one to the digit under the cursor.
// - Down subtracts one from the digit under the cursor.
// - Right moves to a less significant digit or the next field.
// - Left moves to a more significant digit or the previous field.
// - Numeric fields are edited one decimal digit at a time.
// - Up/down step the sixteen-character message field.
// - Priority runs 1 (most urgent) to 32 (least urgent).
// - Alarms show one at a time, oldest first.
// - Confirm takes the value and leaves input mode.
module tsa_text_screen_arbiter
  import tsa_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = SEC_CYC,
  parameter int unsigned BLINK_HALF = BLINK_CYC
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [NSCR-1:0] screen_en_i,
  input wire logic [NSCR-1:0] alarm_ack_input_i,
  input wire logic key_up_i,
  input wire logic key_down_i,
  input wire logic key_left_i,
  input wire logic key_right_i,
  input wire logic input_mode_key_i,
  input wire logic key_ok_i,
  output logic [4:0] shown_screen_o,
  output logic shown_valid_o,
  output logic alarm_shown_o,
  output logic [2:0] lang_index_o,
  output logic [7:0] lang_format_o,
  output logic input_mode_o,
  output logic field_highlight_o,
  output logic cursor_blink_o,
  output logic cursor_field_o,
  output logic [2:0] cursor_digit_o,
  output logic [NDIG*4-1:0] edit_value_o,
  output logic [3:0] edit_msg_o
);
  localparam int NPIN = 2 * NSCR + NKEY;

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      wmerge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
  endfunction : wmerge

  function automatic logic [16:0] clamp_cfg(input logic [16:0] c);
    logic [5:0] p;
    logic [4:0] r;
    p = c[CFG_PRIO_LSB +: 6];
    r = c[CFG_ROLL_LSB +: 5];
    if (p < PRIO_MIN) p = PRIO_MIN;
    if (p > PRIO_MAX) p = PRIO_MAX;
    if (r < ROLL_MIN) r = ROLL_MIN;
    if (r > ROLL_MAX) r = ROLL_MAX;
    clamp_cfg = {c[CFG_ALARM_BIT], 3'h0, r, 2'h0, p};
  endfunction : clamp_cfg

  function automatic logic [3:0] bcd_step(input logic [3:0] d, input logic up);
    if (up) bcd_step = (d >= 4'h9) ? 4'h0 : d + 4'h1;
    else bcd_step = (d == 4'h0 || d > 4'h9) ? 4'h9 : d - 4'h1;
  endfunction : bcd_step

  // Registers
  logic [16:0] scr_cfg [NSCR];
  logic [31:0] lang_ent [NLANG];
  logic cursor_en;
  logic [31:0] lang_oper;
  logic [2:0] lang_def;
  logic lang_match;
  logic [2:0] dig_cnt;
  logic [4:0] msg_cnt;
  logic [NDIG*4-1:0] commit_val;
  logic [3:0] commit_msg;
  logic committed;

  // APB
  logic acc, setup, wr, is_scr, is_lang, rd_hit;
  logic [31:0] rd_data;
  logic [31:0] wm_scr, wm_lang;
  assign setup = psel_i & ~penable_i;
  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i;
  assign pready_o = acc;
  assign is_scr = paddr_i[11:7] == OFF_SCR[11:7];
  assign is_lang = paddr_i[11:5] == OFF_LANG[11:5];
  assign wm_scr = wmerge({15'h0, scr_cfg[paddr_i[6:2]]}, pwdata_i, pstrb_i);
  assign wm_lang = wmerge(lang_ent[paddr_i[4:2]], pwdata_i, pstrb_i);

  always_comb begin
    rd_data = 32'h0;
    rd_hit = 1'b1;
    if (is_scr) begin
      rd_data = {15'h0, scr_cfg[paddr_i[6:2]]};
    end else if (is_lang) begin
      rd_data = lang_ent[paddr_i[4:2]];
    end else begin
      case (paddr_i)
        OFF_CTRL: rd_data = {31'h0, cursor_en};
        OFF_STATUS: rd_data = {20'h0, committed, input_mode_o, alarm_shown_o, shown_valid_o, 3'h0, shown_screen_o};
        OFF_LANG_OPER: rd_data = lang_oper;
        OFF_LANG_DEF: rd_data = {29'h0, lang_def};
        OFF_LANG_STAT: rd_data = {8'h0, lang_format_o, 7'h0, lang_match, 5'h0, lang_index_o};
        OFF_FIELD: rd_data = {19'h0, msg_cnt, 5'h0, dig_cnt};
        OFF_VALUE: rd_data = {12'h0, commit_val};
        OFF_MSG: rd_data = {28'h0, commit_msg};
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // Read data is registered in the setup cycle
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o <= pwrite_i ? 32'h0 : rd_data;
      pslverr_o <= ~rd_hit;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NSCR; i++) scr_cfg[i] <= SCR_CFG_RST;
      for (int k = 0; k < NLANG; k++) lang_ent[k] <= 32'h0;
      cursor_en <= 1'b0;
      lang_oper <= 32'h0;
      lang_def <= 3'h0;
      dig_cnt <= DIG_CNT_RST;
      msg_cnt <= MSG_CNT_RST;
    end else if (wr) begin
      if (is_scr) begin
        scr_cfg[paddr_i[6:2]] <= clamp_cfg(wm_scr[16:0]);
      end else if (is_lang) begin
        lang_ent[paddr_i[4:2]] <= wm_lang;
      end else begin
        case (paddr_i)
          OFF_CTRL: cursor_en <= pstrb_i[0] ? pwdata_i[0] : cursor_en;
          OFF_LANG_OPER: lang_oper <= wmerge(lang_oper, pwdata_i, pstrb_i);
          OFF_LANG_DEF: lang_def <= pstrb_i[0] ? pwdata_i[2:0] : lang_def;
          OFF_FIELD: begin
            if (pstrb_i[0]) dig_cnt <= (pwdata_i[FLD_DIG_LSB +: 3] == 3'h0) ? 3'h1 :
              (pwdata_i[FLD_DIG_LSB +: 3] > 3'(NDIG)) ? 3'(NDIG) : pwdata_i[FLD_DIG_LSB +: 3];
            if (pstrb_i[1]) msg_cnt <= (pwdata_i[FLD_MSG_LSB +: 5] == 5'h0) ? 5'h1 :
              (pwdata_i[FLD_MSG_LSB +: 5] > 5'h10) ? 5'h10 : pwdata_i[FLD_MSG_LSB +: 5];
          end
          default: ;
        endcase
      end
    end
  end

  // Pin filter: second and third stages must agree
  logic [NPIN-1:0] pin_s1, pin_s2, pin_s3, pin_f, pin_d, pin_r;
  logic [NSCR-1:0] en, en_r, ack_r;
  logic [NKEY-1:0] key_p;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_f <= '0;
      pin_d <= '0;
    end else begin
      pin_s1 <= {key_ok_i, input_mode_key_i, key_right_i, key_left_i, key_down_i, key_up_i,
                 alarm_ack_input_i, screen_en_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= ((pin_s2 ~^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_f);
      pin_d <= pin_f;
    end
  end
  assign pin_r = pin_f & ~pin_d;
  assign en = pin_f[NSCR-1:0];
  assign en_r = pin_r[NSCR-1:0];
  assign ack_r = pin_r[2*NSCR-1:NSCR];
  assign key_p = pin_r[NPIN-1:2*NSCR];

  // Alarm queue: rank 0 is the oldest pending alarm
  logic [NSCR-1:0] alarm_scr, pend, drop, add;
  logic [4:0] rank [NSCR];
  logic [4:0] next_rank [NSCR];
  logic [4:0] head;
  logic head_v;
  always_comb begin
    int nsurv;
    int nadd;
    int lower;
    nsurv = 0;
    nadd = 0;
    lower = 0;
    head = 5'h0;
    head_v = 1'b0;
    for (int i = 0; i < NSCR; i++) begin
      alarm_scr[i] = scr_cfg[i][CFG_ALARM_BIT];
      drop[i] = pend[i] & (~en[i] | ack_r[i]);
      add[i] = en_r[i] & alarm_scr[i] & ~pend[i];
      if (pend[i] && rank[i] == 5'h0) begin
        head = 5'(i);
        head_v = 1'b1;
      end
      if (pend[i] && !drop[i]) nsurv++;
    end
    for (int i = 0; i < NSCR; i++) begin
      lower = 0;
      for (int j = 0; j < NSCR; j++) begin
        if (drop[j] && rank[j] < rank[i]) lower++;
      end
      next_rank[i] = pend[i] ? rank[i] - 5'(lower) : rank[i];
      if (add[i]) begin
        next_rank[i] = 5'(nsurv + nadd);
        nadd++;
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend <= '0;
      for (int i = 0; i < NSCR; i++) rank[i] <= 5'h0;
    end else begin
      pend <= (pend & ~drop) | add;
      for (int i = 0; i < NSCR; i++) rank[i] <= next_rank[i];
    end
  end

  // Normal screens: lowest priority number wins, equals rotate
  logic [NSCR-1:0] cand;
  logic [5:0] pmin;
  logic [4:0] first, rot, cur_idx;
  logic cur_v, keep, roll_done, sec_tick;
  logic [4:0] roll_cnt;
  logic [31:0] div_cnt;
  always_comb begin
    logic found;
    found = 1'b0;
    pmin = 6'h3f;
    first = 5'h0;
    rot = cur_idx;
    for (int i = 0; i < NSCR; i++) begin
      if (en[i] && !alarm_scr[i] && scr_cfg[i][CFG_PRIO_LSB +: 6] < pmin) pmin = scr_cfg[i][CFG_PRIO_LSB +: 6];
    end
    for (int i = 0; i < NSCR; i++) begin
      cand[i] = en[i] & ~alarm_scr[i] & (scr_cfg[i][CFG_PRIO_LSB +: 6] == pmin);
    end
    for (int i = NSCR - 1; i >= 0; i--) begin
      if (cand[i]) first = 5'(i);
    end
    for (int k = 1; k <= NSCR; k++) begin
      if (!found && cand[5'(cur_idx + 5'(k))]) begin
        rot = 5'(cur_idx + 5'(k));
        found = 1'b1;
      end
    end
  end
  // A lost enable or a better priority breaks the hold
  assign keep = cur_v & cand[cur_idx];
  assign sec_tick = keep && div_cnt == CYC_PER_SEC - 1;
  assign roll_done = sec_tick && (roll_cnt + 5'h1 >= scr_cfg[cur_idx][CFG_ROLL_LSB +: 5]);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_cnt <= 32'h0;
    end else if (!keep || sec_tick) begin
      div_cnt <= 32'h0;
    end else begin
      div_cnt <= div_cnt + 32'h1;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_idx <= 5'h0;
      cur_v <= 1'b0;
      roll_cnt <= 5'h0;
    end else if (!keep) begin
      cur_idx <= first;
      cur_v <= |cand;
      roll_cnt <= 5'h0;
    end else if (roll_done) begin
      cur_idx <= rot;
      roll_cnt <= 5'h0;
    end else if (sec_tick) begin
      roll_cnt <= roll_cnt + 5'h1;
    end
  end

  // A pending alarm always overrides the normal choice
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shown_screen_o <= 5'h0;
      shown_valid_o <= 1'b0;
      alarm_shown_o <= 1'b0;
    end else begin
      shown_screen_o <= head_v ? head : cur_idx;
      shown_valid_o <= head_v | cur_v;
      alarm_shown_o <= head_v;
    end
  end

  // Language: first matching valid entry, else the default
  logic [2:0] lsel;
  logic lmatch;
  always_comb begin
    lsel = lang_def;
    lmatch = 1'b0;
    for (int k = NLANG - 1; k >= 0; k--) begin
      if (lang_ent[k][LE_VALID_BIT] && {16'h0, lang_ent[k][LE_VAL_LSB +: 16]} == lang_oper) begin
        lsel = 3'(k);
        lmatch = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lang_index_o <= 3'h0;
      lang_format_o <= 8'h0;
      lang_match <= 1'b0;
    end else begin
      lang_index_o <= lsel;
      lang_format_o <= lang_ent[lsel][LE_FMT_LSB +: 8];
      lang_match <= lmatch;
    end
  end

  // Input mode
  tsa_imode_e im_state, next_im;
  logic confirm;
  assign confirm = (im_state == IM_EDIT) & key_p[KEY_OK];
  always_comb begin
    case (im_state)
      IM_IDLE: next_im = (cursor_en && key_p[KEY_MODE]) ? IM_EDIT : IM_IDLE;
      IM_EDIT: next_im = (!cursor_en || key_p[KEY_OK]) ? IM_IDLE : IM_EDIT;
      default: next_im = IM_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) im_state <= IM_IDLE;
    else im_state <= next_im;
  end
  assign input_mode_o = im_state == IM_EDIT;
  assign field_highlight_o = input_mode_o;

  logic [NDIG*4-1:0] ed_val;
  logic [3:0] ed_msg;
  always_comb begin
    ed_val = edit_value_o;
    ed_msg = edit_msg_o;
    if (key_p[KEY_UP] || key_p[KEY_DOWN]) begin
      if (!cursor_field_o) begin
        ed_val[cursor_digit_o*4 +: 4] = bcd_step(edit_value_o[cursor_digit_o*4 +: 4], key_p[KEY_UP]);
      end else if (key_p[KEY_UP]) begin
        ed_msg = ({1'b0, edit_msg_o} + 5'h1 >= msg_cnt) ? 4'h0 : edit_msg_o + 4'h1;
      end else begin
        ed_msg = (edit_msg_o == 4'h0) ? 4'(msg_cnt - 5'h1) : edit_msg_o - 4'h1;
      end
    end
  end

  // One key per cycle; up/down beat cursor moves
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      edit_value_o <= '0;
      edit_msg_o <= 4'h0;
      cursor_field_o <= 1'b0;
      cursor_digit_o <= 3'h0;
    end else if (im_state == IM_IDLE) begin
      if (next_im == IM_EDIT) begin
        edit_value_o <= commit_val;
        edit_msg_o <= commit_msg;
        cursor_field_o <= 1'b0;
        cursor_digit_o <= dig_cnt - 3'h1;
      end
    end else if (key_p[KEY_UP] || key_p[KEY_DOWN]) begin
      edit_value_o <= ed_val;
      edit_msg_o <= ed_msg;
    end else if (key_p[KEY_RIGHT]) begin
      if (cursor_field_o) cursor_field_o <= 1'b1;
      else if (cursor_digit_o != 3'h0) cursor_digit_o <= cursor_digit_o - 3'h1;
      else cursor_field_o <= 1'b1;
    end else if (key_p[KEY_LEFT]) begin
      if (cursor_field_o) begin
        cursor_field_o <= 1'b0;
        cursor_digit_o <= 3'h0;
      end else if (cursor_digit_o < dig_cnt - 3'h1) begin
        cursor_digit_o <= cursor_digit_o + 3'h1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      commit_val <= '0;
      commit_msg <= 4'h0;
    end else if (confirm) begin
      commit_val <= edit_value_o;
      commit_msg <= edit_msg_o;
    end
  end

  // Write one clears; a same-cycle confirm wins
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) committed <= 1'b0;
    else if (confirm) committed <= 1'b1;
    else if (wr && paddr_i == OFF_STATUS && pstrb_i[1] && pwdata_i[STAT_COMMIT_BIT]) committed <= 1'b0;
  end

  logic [31:0] blink_cnt;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      blink_cnt <= 32'h0;
      cursor_blink_o <= 1'b0;
    end else if (!input_mode_o) begin
      blink_cnt <= 32'h0;
      cursor_blink_o <= 1'b1;
    end else if (blink_cnt == BLINK_HALF - 1) begin
      blink_cnt <= 32'h0;
      cursor_blink_o <= ~cursor_blink_o;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end
endmodule : tsa_text_screen_arbiter
`default_nettype wire

/* File: rtl/tsa_pkg.sv */
// Purpose: Shared constants for the text screen arbiter.
// Assumes: 25 MHz clock, APB register access with 12 address bits.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package tsa_pkg;
  localparam int NSCR = 32;
  localparam int NLANG = 8;
  localparam int NDIG = 5;
  localparam int NKEY = 6;
  localparam int CLK_HZ = 25_000_000;
  localparam int SEC_MS = 1000;
  localparam int BLINK_MS = 250;
  localparam int SEC_CYC = CLK_HZ / 1000 * SEC_MS;
  localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  localparam int MSG_AREA_CHARS = 16;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_LANG_OPER = 12'h008;
  localparam logic [11:0] OFF_LANG_DEF = 12'h00c;
  localparam logic [11:0] OFF_LANG_STAT = 12'h010;
  localparam logic [11:0] OFF_FIELD = 12'h014;
  localparam logic [11:0] OFF_VALUE = 12'h018;
  localparam logic [11:0] OFF_MSG = 12'h01c;
  localparam logic [11:0] OFF_LANG = 12'h040;
  localparam logic [11:0] OFF_SCR = 12'h100;
  localparam int CFG_PRIO_LSB = 0;
  localparam int CFG_ROLL_LSB = 8;
  localparam int CFG_ALARM_BIT = 16;
  localparam int LE_VAL_LSB = 0;
  localparam int LE_FMT_LSB = 16;
  localparam int LE_VALID_BIT = 31;
  localparam int STAT_COMMIT_BIT = 11;
  localparam int FLD_DIG_LSB = 0;
  localparam int FLD_MSG_LSB = 8;
  localparam logic [5:0] PRIO_MIN = 6'h01;
  localparam logic [5:0] PRIO_MAX = 6'h20;
  localparam logic [4:0] ROLL_MIN = 5'h01;
  localparam logic [4:0] ROLL_MAX = 5'h1e;
  localparam logic [16:0] SCR_CFG_RST = 17'h00120;
  localparam logic [2:0] DIG_CNT_RST = 3'h3;
  localparam logic [4:0] MSG_CNT_RST = 5'h10;
  localparam int KEY_UP = 0;
  localparam int KEY_DOWN = 1;
  localparam int KEY_LEFT = 2;
  localparam int KEY_RIGHT = 3;
  localparam int KEY_MODE = 4;
  localparam int KEY_OK = 5;
  typedef enum logic [1:0] {IM_IDLE = 2'b01, IM_EDIT = 2'b10} tsa_imode_e;
endpackage : tsa_pkg

/* File: sim/tsa_arbiter_properties.sv */
// Purpose: Port properties of the arbiter.
// Assumes: One clock, async low reset.
// Notes: Bound from tb_top.
`timescale 1ns/1ns
`default_nettype none
module tsa_arbiter_properties
  import tsa_pkg::*;
#(
  parameter int unsigned BLINK_HALF = BLINK_CYC
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [NSCR-1:0] screen_en_i,
  input wire logic [4:0] shown_screen_o,
  input wire logic shown_valid_o,
  input wire logic alarm_shown_o,
  input wire logic input_mode_o,
  input wire logic field_highlight_o,
  input wire logic cursor_blink_o,
  input wire logic cursor_field_o,
  input wire logic [2:0] cursor_digit_o,
  input wire logic [NDIG*4-1:0] edit_value_o,
  input wire logic [3:0] edit_msg_o
);
  // Slack for the registered output
  localparam int BLINK_WIN = BLINK_HALF + 2;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  highlight_mode_a: assert property (field_highlight_o == input_mode_o)
    else $error("highlight not input mode");
  idle_blink_a: assert property (!input_mode_o [*3] |-> cursor_blink_o)
    else $error("blink low when idle");
  blink_run_a: assert property (input_mode_o && $changed(cursor_blink_o) |=>
    ##[0:BLINK_WIN] ($changed(cursor_blink_o) || !input_mode_o))
    else $error("blink stopped");
  alarm_valid_a: assert property (alarm_shown_o |-> shown_valid_o)
    else $error("alarm without screen");
  none_enabled_a: assert property ((screen_en_i == '0) [*8] |-> ##2 !shown_valid_o)
    else $error("screen shown with no enable");
  digit_only_a: assert property (input_mode_o && $past(input_mode_o) && $changed(edit_value_o) |->
    !$past(cursor_field_o) && ((edit_value_o ^ $past(edit_value_o)) & ~(20'hf << (4 * $past(cursor_digit_o)))) == '0)
    else $error("value changed off cursor");
  msg_field_a: assert property (input_mode_o && $past(input_mode_o) && $changed(edit_msg_o) |->
    $past(cursor_field_o))
    else $error("message changed off field");
  cursor_step_a: assert property (input_mode_o && $past(input_mode_o) && !cursor_field_o
    && !$past(cursor_field_o) && $changed(cursor_digit_o) |->
    cursor_digit_o == $past(cursor_digit_o) + 3'h1 || cursor_digit_o + 3'h1 == $past(cursor_digit_o))
    else $error("cursor jumped");
  entry_field_a: assert property ($rose(input_mode_o) |-> !cursor_field_o)
    else $error("entry off numeric field");
  reset_state_a: assert property ($rose(resetn_i) |-> !shown_valid_o && !input_mode_o && edit_value_o == '0)
    else $error("state not cleared by reset");

  alarm_c: cover property ($rose(alarm_shown_o));
  mode_c: cover property ($rose(input_mode_o));
  rotate_c: cover property (shown_valid_o && !alarm_shown_o && $changed(shown_screen_o));
endmodule : tsa_arbiter_properties
`default_nettype wire

/* File: sim/tsa_keypad_model.sv */
// Purpose: Operator keypad model.
// Assumes: A press is a rising edge on a level pin.
// Notes: Key held six cycles, then six at rest.
`timescale 1ns/1ns
`default_nettype none
module tsa_keypad_model (
  input wire logic clock_i,
  input wire logic press_i,
  input wire logic [2:0] sel_i,
  output logic [5:0] keys_o,
  output logic busy_o
);
  int cnt = 0;
  logic [2:0] sel = 3'h0;
  always @(posedge clock_i) begin
    if (cnt != 0) begin
      cnt <= cnt - 1;
    end else if (press_i) begin
      cnt <= 12;
      sel <= sel_i;
    end
  end
  // Long hold so the pin filter sees each press
  assign keys_o = (cnt > 6) ? 6'h01 << sel : 6'h00;
  assign busy_o = cnt != 0;
endmodule : tsa_keypad_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the arbiter.
// Assumes: Second and blink counts shortened.
// Notes: Expected values come from an integer model.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import tsa_pkg::*;
  localparam int CPS = 20;
  logic clock_i, resetn_i, psel, penable, pwrite, press, pready, pslverr, sv, as, im, cf, kbusy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, sen, ack;
  logic [4:0] ss;
  logic [2:0] li, cd, ksel;
  logic [7:0] lf;
  logic [19:0] ev;
  logic [3:0] em;
  logic [5:0] keys;
  int error_cnt = 0;
  int cmp_count = 0;
  int prio[NSCR], en[NSCR], alm[NSCR], aq[$], dig[NDIG];
  int cur, fld, msg, mode, ctl, n;
  int seq[10] = '{KEY_UP, KEY_DOWN, KEY_DOWN, KEY_RIGHT, KEY_UP, KEY_RIGHT, KEY_RIGHT, KEY_UP, KEY_LEFT, KEY_LEFT};

  tsa_text_screen_arbiter #(.CYC_PER_SEC(CPS), .BLINK_HALF(8)) DUT (
    .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .screen_en_i(sen), .alarm_ack_input_i(ack), .key_up_i(keys[KEY_UP]),
    .key_down_i(keys[KEY_DOWN]), .key_left_i(keys[KEY_LEFT]), .key_right_i(keys[KEY_RIGHT]),
    .input_mode_key_i(keys[KEY_MODE]), .key_ok_i(keys[KEY_OK]), .shown_screen_o(ss),
    .shown_valid_o(sv), .alarm_shown_o(as), .lang_index_o(li), .lang_format_o(lf),
    .input_mode_o(im), .field_highlight_o(), .cursor_blink_o(), .cursor_field_o(cf),
    .cursor_digit_o(cd), .edit_value_o(ev), .edit_msg_o(em));
  tsa_keypad_model u_keys (.clock_i(clock_i), .press_i(press), .sel_i(ksel), .keys_o(keys), .busy_o(kbusy));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_out

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
    int t = 0;
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
      t++;
    end while (pready !== 1'b1 && t < 16);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  task automatic chk_reg(input logic [11:0] a, input logic [32:0] exp);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    cmp_count++;
    if (r !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: read %h expected %h", $time, r, exp);
    end
  endtask : chk_reg

  function automatic logic [31:0] probe(input int w);
    case (w)
      0: return {25'h0, as, sv, sv ? ss : 5'h0};
      1: return {16'h0, lf, 5'h0, li};
      2: return im ? {27'h0, cf, cd, im} : 32'h0;
      3: return {12'h0, ev};
      default: return {28'h0, em};
    endcase
  endfunction : probe

  // Pin path latency is several cycles, so poll
  task automatic settle(input int w, input logic [31:0] exp);
    int t = 0;
    while (probe(w) !== exp && t < 64) begin
      @(posedge clock_i);
      t++;
    end
    chk_out(probe(w), exp);
    if (probe(w) !== exp) wrap_up();
  endtask : settle

  function automatic logic [31:0] exp_scr();
    int b;
    b = -1;
    if (aq.size() > 0) return {25'h0, 2'b11, 5'(aq[0])};
    for (int i = 0; i < NSCR; i++) begin
      if (en[i] != 0 && alm[i] == 0 && (b < 0 || prio[i] < prio[b])) b = i;
    end
    return (b < 0) ? 32'h0 : {25'h0, 2'b01, 5'(b)};
  endfunction : exp_scr

  task automatic cfg(input int i, input int p, input int r, input int a);
    prio[i] = p;
    alm[i] = a;
    wr(OFF_SCR + 12'(4 * i), 32'((a << 16) | (r << 8) | p));
  endtask : cfg

  task automatic set_en(input int i, input int v);
    @(posedge clock_i);
    sen[i] <= v[0];
    en[i] = v;
    if (v != 0 && alm[i] != 0) aq.push_back(i);
  endtask : set_en

  task automatic ack_head();
    int i;
    i = aq.pop_front();
    @(posedge clock_i);
    ack[i] <= 1'b1;
    repeat (6) @(posedge clock_i);
    ack[i] <= 1'b0;
  endtask : ack_head

  task automatic key(input int k);
    int t;
    int v;
    @(posedge clock_i);
    press <= 1'b1;
    ksel <= 3'(k);
    @(posedge clock_i);
    press <= 1'b0;
    t = 0;
    do begin
      @(posedge clock_i);
      t++;
    end while (kbusy !== 1'b0 && t < 30);
    if (kbusy !== 1'b0) begin
      error_cnt++;
      wrap_up();
    end
    if (mode != 0) begin
      case (k)
        KEY_UP: if (fld != 0) msg = (msg + 1) % 16; else dig[cur] = (dig[cur] + 1) % 10;
        KEY_DOWN: if (fld != 0) msg = (msg + 15) % 16; else dig[cur] = (dig[cur] + 9) % 10;
        KEY_RIGHT: if (fld == 0 && cur == 0) fld = 1; else if (fld == 0) cur--;
        KEY_LEFT: if (fld != 0) fld = 0; else if (cur < 2) cur++;
        KEY_OK: mode = 0;
        default: ;
      endcase
    end else if (k == KEY_MODE && ctl != 0) begin
      mode = 1;
      cur = 2;
      fld = 0;
    end
    v = 0;
    for (int j = NDIG - 1; j >= 0; j--) v = v * 16 + dig[j];
    settle(2, mode != 0 ? 32'(fld * 16 + cur * 2 + 1) : 32'h0);
    settle(3, 32'(v));
    settle(4, 32'(msg));
  endtask : key

  initial begin
    resetn_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    press = 1'b0;
    ksel = 3'h0;
    sen = 32'h0;
    ack = 32'h0;
    void'($urandom(32'h3eadcc11));
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    chk_reg(OFF_FIELD, 33'h1003);
    chk_reg(OFF_SCR + 12'h14, 33'h120);
    chk_reg(12'h800, 33'h1_0000_0000);
    $display("test registers done");
    cfg(3, 2, 1, 0);
    cfg(7, 5, 1, 0);
    cfg(9, 32, 1, 1);
    cfg(10, 32, 1, 1);
    set_en(7, 1);
    settle(0, exp_scr());
    set_en(3, 1);
    settle(0, exp_scr());
    set_en(3, 0);
    settle(0, exp_scr());
    $display("test priority done");
    set_en(9, 1);
    set_en(10, 1);
    settle(0, exp_scr());
    ack_head();
    settle(0, exp_scr());
    ack_head();
    settle(0, exp_scr());
    $display("test alarms done");
    cfg(12, 4, 1, 0);
    cfg(13, 4, 2, 0);
    set_en(12, 1);
    set_en(13, 1);
    settle(0, 32'h2d);
    n = 0;
    while (probe(0) === 32'h2d && n < 100) begin
      @(posedge clock_i);
      n++;
    end
    chk_out(probe(0), 32'h2c);
    chk_out(32'(n >= 2 * CPS - 2 && n <= 2 * CPS + 2), 32'h1);
    set_en(3, 1);
    settle(0, exp_scr());
    for (int i = 0; i < NSCR; i++) set_en(i, 0);
    settle(0, 32'h0);
    $display("test rotation done");
    wr(OFF_LANG + 12'h08, 32'h805a_0011);
    wr(OFF_LANG + 12'h14, 32'h803c_0022);
    wr(OFF_LANG + 12'h10, 32'h8081_7777);
    wr(OFF_LANG_DEF, 32'h4);
    wr(OFF_LANG_OPER, 32'h22);
    settle(1, 32'h3c05);
    wr(OFF_LANG_OPER, 32'h11);
    settle(1, 32'h5a02);
    repeat (3) begin
      wr(OFF_LANG_OPER, $urandom | 32'h1_0000);
      settle(1, 32'h8104);
    end
    $display("test language done");
    key(KEY_MODE);
    key(KEY_UP);
    ctl = 1;
    wr(OFF_CTRL, 32'h1);
    key(KEY_MODE);
    foreach (seq[j]) key(seq[j]);
    key(KEY_OK);
    chk_reg(OFF_VALUE, 33'h910);
    chk_reg(OFF_MSG, 33'h1);
    $display("test entry done");
    @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    chk_reg(OFF_CTRL, 33'h0);
    chk_reg(OFF_SCR + 12'h0c, 33'h120);
    settle(0, 32'h0);
    $display("test reset done");
    wrap_up();
  end
endmodule : tb_top

bind tsa_text_screen_arbiter tsa_arbiter_properties #(.BLINK_HALF(BLINK_HALF)) u_props (.*);
`default_nettype wire
